// file: logic/ata_cmd_block_decoder.sv
`timescale 1ns/1ns
module ata_cmd_block_decoder
    import cmd_block_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_CFG_SIGNATURE,
    input wire logic [7:0] I_CFG_DRIVE_BYTE,
    input wire logic I_BLOCK_VALID,
    input wire logic [BLOCK_BYTES*8-1:0] I_BLOCK,
    input wire logic I_TF_DONE,
    input wire logic [7:0] I_TF_RDATA,
    output logic O_BLOCK_READY,
    output logic O_NORMAL_PATH,
    output logic [BLOCK_BYTES*8-1:0] O_NORMAL_BLOCK,
    output exec_cfg_s O_EXEC_CFG,
    output logic O_TF_REQ,
    output tf_req_s O_TF,
    output logic O_EXEC_START,
    output logic O_IMAGE_VALID,
    output logic [IMAGE_BYTES*8-1:0] O_IMAGE
);
    typedef enum {S_IDLE, S_POLL, S_SELECT, S_REGS, S_SELECT_LATE,
                  S_DONE} state_e;

    state_e state_r;
    logic [BLOCK_BYTES*8-1:0] blk_r;
    action_s act_r;
    logic [7:0] image_r [IMAGE_BYTES];
    logic tf_busy_r;
    logic seq_load;
    logic seq_adv;
    logic seq_active;
    logic [2:0] seq_idx;
    logic dev_bit;

    function automatic logic [7:0] blk_byte(
        input logic [BLOCK_BYTES*8-1:0] b,
        input int n
    );
        blk_byte = b[n*8 +: 8];
    endfunction

    // ------------------------------------------------
    // Block recognition
    // ------------------------------------------------
    wire logic is_ata = blk_byte(I_BLOCK, BYTE_SIG) == I_CFG_SIGNATURE &&
        blk_byte(I_BLOCK, BYTE_SUB) == SUBCMD_ATA; // RL1
    wire logic accept = I_BLOCK_VALID && state_r == S_IDLE;
    assign O_BLOCK_READY = state_r == S_IDLE;

    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_NORMAL_PATH <= 1'b0;
            O_NORMAL_BLOCK <= '0;
        end
        else
        begin
            O_NORMAL_PATH <= accept && !is_ata; // RL18
            if (accept && !is_ata)
            begin
                O_NORMAL_BLOCK <= I_BLOCK; // RL18
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            blk_r <= '0;
            act_r <= '0;
        end
        else if (accept && is_ata)
        begin
            blk_r <= I_BLOCK;
            act_r <= action_s'(blk_byte(I_BLOCK, BYTE_ACTION));
        end
    end

    // ------------------------------------------------
    // Action decode
    // ------------------------------------------------
    assign dev_bit = act_r.drive_select_source ?
        blk_r[BYTE_DEVHEAD*8 + BLK_DEV_BIT] :
        I_CFG_DRIVE_BYTE[CFG_DEV_BIT]; // RL7

    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_EXEC_CFG <= '0;
        end
        else
        begin
            O_EXEC_CFG.identify_data_flag <= act_r.identify_data_flag; // RL3
            O_EXEC_CFG.ultra_dma_enable <= act_r.ultra_dma_enable; // RL5
            O_EXEC_CFG.drive_select_bit <= dev_bit; // RL7
            O_EXEC_CFG.halt_on_device_err <=
                !act_r.error_halt_override[1]; // RL8
            O_EXEC_CFG.halt_on_phase_err <=
                !act_r.error_halt_override[0]; // RL8
            O_EXEC_CFG.select_after_command <=
                act_r.select_after_command; // RL11
            O_EXEC_CFG.register_readback_only <=
                act_r.register_readback_only; // RL12
        end
    end

    // ------------------------------------------------
    // Sequencer
    // ------------------------------------------------
    assign seq_load = state_r == S_SELECT &&
        (act_r.select_after_command || act_r.register_readback_only ||
        (tf_busy_r && I_TF_DONE)); // RL17
    assign seq_adv = state_r == S_REGS && tf_busy_r && I_TF_DONE;

    reg_sequencer u_seq (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_load(seq_load),
        .i_mask(blk_byte(blk_r, BYTE_SELECT)),
        .i_advance(seq_adv),
        .o_active(seq_active),
        .o_idx(seq_idx)
    );

    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            state_r <= S_IDLE;
            tf_busy_r <= 1'b0;
            O_TF_REQ <= 1'b0;
            O_TF <= '0;
            O_EXEC_START <= 1'b0;
            O_IMAGE_VALID <= 1'b0;
        end
        else
        begin
            O_TF_REQ <= 1'b0;
            O_EXEC_START <= 1'b0;
            O_IMAGE_VALID <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (accept && is_ata)
                    begin
                        state_r <= S_POLL;
                    end
                end
                S_POLL:
                begin
                    if (act_r.skip_busy_poll)
                    begin
                        state_r <= S_SELECT; // RL10
                    end
                    else if (!tf_busy_r)
                    begin
                        O_TF_REQ <= 1'b1;
                        O_TF <= '{idx: ALT_STATUS_IDX, wr: 1'b0,
                            data: 8'h00}; // RL10
                        tf_busy_r <= 1'b1;
                    end
                    else if (I_TF_DONE)
                    begin
                        tf_busy_r <= 1'b0;
                        if (!I_TF_RDATA[BUSY_BIT])
                        begin
                            state_r <= S_SELECT; // RL10
                        end
                    end
                end
                S_SELECT:
                begin
                    if (act_r.select_after_command ||
                        act_r.register_readback_only)
                    begin
                        state_r <= S_REGS; // RL11
                    end
                    else if (!tf_busy_r)
                    begin
                        O_TF_REQ <= 1'b1;
                        O_TF <= '{idx: DEVHEAD_IDX, wr: 1'b1,
                            data: {3'h0, dev_bit, 4'h0}}; // RL11
                        tf_busy_r <= 1'b1;
                    end
                    else if (I_TF_DONE)
                    begin
                        tf_busy_r <= 1'b0;
                        state_r <= S_REGS;
                    end
                end
                S_REGS:
                begin
                    if (!tf_busy_r && seq_active)
                    begin
                        O_TF_REQ <= 1'b1; // RL17
                        O_TF <= '{idx: seq_idx,
                            wr: !act_r.register_readback_only,
                            data: blk_byte(blk_r,
                                BYTE_WDATA + int'(seq_idx))};
                        tf_busy_r <= 1'b1;
                    end
                    else if (tf_busy_r && I_TF_DONE)
                    begin
                        tf_busy_r <= 1'b0;
                    end
                    else if (!tf_busy_r)
                    begin
                        state_r <= act_r.select_after_command &&
                            !act_r.register_readback_only ?
                            S_SELECT_LATE : S_DONE;
                    end
                end
                S_SELECT_LATE:
                begin
                    if (!tf_busy_r)
                    begin
                        O_TF_REQ <= 1'b1;
                        O_TF <= '{idx: DEVHEAD_IDX, wr: 1'b1,
                            data: {3'h0, dev_bit, 4'h0}}; // RL11
                        tf_busy_r <= 1'b1;
                    end
                    else if (I_TF_DONE)
                    begin
                        tf_busy_r <= 1'b0;
                        state_r <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    O_IMAGE_VALID <= act_r.register_readback_only; // RL12
                    O_EXEC_START <= !act_r.register_readback_only; // RL12
                    state_r <= S_IDLE;
                end
                default:
                begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // Readback image
    // ------------------------------------------------
    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < IMAGE_BYTES; i++)
            begin
                image_r[i] <= UNSELECTED_FILL;
            end
        end
        else if (accept && is_ata)
        begin
            for (int i = 0; i < IMAGE_BYTES; i++)
            begin
                image_r[i] <= UNSELECTED_FILL; // RL12
            end
        end
        else if (seq_adv && act_r.register_readback_only)
        begin
            image_r[seq_idx] <= I_TF_RDATA; // RL14 RL15
        end
    end

    generate
        for (genvar g = 0; g < IMAGE_BYTES; g++)
        begin : g_img
            assign O_IMAGE[g*8 +: 8] = image_r[g]; // RL14 RL15
        end
    endgenerate
endmodule

// file: pkg/cmd_block_pkg.sv
// How it works
// RL1: Block is vendor-specific only when byte 0 equals configured signature.
// RL2: Host puts subcommand 0x24 in byte 1 for command block processing.
// RL3: Action bit 7 marks data phase as identify data, else ordinary.
// RL4: Host sets identify bit only when data really is identify data.
// RL5: Action bit 6 set selects ultra DMA, clear selects PIO only.
// RL6: Host never sets ultra DMA bit for a drive lacking it.
// RL7: Bit 5 clear: drive select from config bit 5; set: byte 11 bit 4.
// RL8: Bits 4:3 choose which of device or phase errors halt data.
// RL9: Host never sets error override bits together with readback-only.
// RL10: Bit 2 clear: poll alternate status until busy clears, then start.
// RL11: Bit 1 clear selects drive before command writes, set after them.
// RL12: Bit 0 set: only read selected registers, zero for unselected ones.
// RL13: Host sets transfer length to exactly 8 for readback-only.
// RL14: Image offsets 0..3: alternate status, error, sector count, number.
// RL15: Image offsets 4..7: cylinder low, high, device/head, status.
// RL16: Host sends the command block exactly 16 bytes long.
// RL17: Register accesses run one at a time, select bit 0 upward.
// RL18: Mismatched signature or subcommand goes to the normal command path.
package cmd_block_pkg;
    localparam int BLOCK_BYTES = 16;
    localparam logic [7:0] SUBCMD_ATA = 8'h24;
    localparam int BYTE_SIG = 0;
    localparam int BYTE_SUB = 1;
    localparam int BYTE_ACTION = 2;
    localparam int BYTE_SELECT = 3;
    localparam int BYTE_DEVHEAD = 11;
    localparam int BYTE_WDATA = 4;
    localparam logic [2:0] DEVHEAD_IDX = 3'h6;
    localparam int BIT_IDENT = 7;
    localparam int BIT_UDMA = 6;
    localparam int BIT_DEVSRC = 5;
    localparam int BIT_ERR_HI = 4;
    localparam int BIT_ERR_LO = 3;
    localparam int BIT_NOPOLL = 2;
    localparam int BIT_SELAFTER = 1;
    localparam int BIT_READONLY = 0;
    localparam int CFG_DEV_BIT = 5;
    localparam int BLK_DEV_BIT = 4;
    localparam int BUSY_BIT = 7;
    localparam int IMAGE_BYTES = 8;
    localparam logic [2:0] ALT_STATUS_IDX = 3'h0;
    localparam logic [7:0] UNSELECTED_FILL = 8'h00;

    typedef struct packed {
        logic identify_data_flag;
        logic ultra_dma_enable;
        logic drive_select_source;
        logic [1:0] error_halt_override;
        logic skip_busy_poll;
        logic select_after_command;
        logic register_readback_only;
    } action_s;

    typedef struct packed {
        logic halt_on_device_err;
        logic halt_on_phase_err;
        logic drive_select_bit;
        logic identify_data_flag;
        logic ultra_dma_enable;
        logic select_after_command;
        logic register_readback_only;
    } exec_cfg_s;

    typedef struct packed {
        logic [2:0] idx;
        logic wr;
        logic [7:0] data;
    } tf_req_s;
endpackage

// file: logic/reg_sequencer.sv
`timescale 1ns/1ns
module reg_sequencer
    import cmd_block_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [7:0] i_mask,
    input wire logic i_advance,
    output logic o_active,
    output logic [2:0] o_idx
);
    logic [7:0] pend_r;
    logic [2:0] low;

    always_comb
    begin
        low = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (pend_r[i])
            begin
                low = 3'(i); // RL17
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pend_r <= 8'h00;
        end
        else if (i_load)
        begin
            pend_r <= i_mask;
        end
        else if (i_advance && o_active)
        begin
            pend_r[low] <= 1'b0; // RL17
        end
    end

    assign o_active = |pend_r;
    assign o_idx = low;
endmodule

// file: verification/ata_cmd_block_decoder_chk.sv
`timescale 1ns/1ns
module ata_cmd_block_decoder_chk
    import cmd_block_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_CFG_SIGNATURE,
    input wire logic [7:0] I_CFG_DRIVE_BYTE,
    input wire logic I_BLOCK_VALID,
    input wire logic [BLOCK_BYTES*8-1:0] I_BLOCK,
    input wire logic I_TF_DONE,
    input wire logic O_BLOCK_READY,
    input wire logic O_NORMAL_PATH,
    input wire logic [BLOCK_BYTES*8-1:0] O_NORMAL_BLOCK,
    input wire exec_cfg_s O_EXEC_CFG,
    input wire logic O_TF_REQ,
    input wire logic O_EXEC_START,
    input wire logic O_IMAGE_VALID
);
    // -------
    // Checks
    // -------
    logic take;
    logic hit;
    logic open_r;
    assign take = I_BLOCK_VALID && O_BLOCK_READY;
    assign hit = I_BLOCK[7:0] == I_CFG_SIGNATURE
        && I_BLOCK[15:8] == SUBCMD_ATA;
    always_ff @(posedge I_CLK_SYS or posedge I_RST)
        if (I_RST)
            open_r <= 1'b0;
        else if (O_TF_REQ || I_TF_DONE)
            open_r <= O_TF_REQ;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    property p_one; O_TF_REQ |-> !open_r; endproperty
    a_one: assert property (p_one) else $error("overlap");
    property p_miss; take && !hit |=> O_NORMAL_PATH
        && O_NORMAL_BLOCK == $past(I_BLOCK); endproperty
    a_miss: assert property (p_miss) else $error("no pass-on");
    property p_hit; take && hit |=> !O_NORMAL_PATH [*3]; endproperty
    a_hit: assert property (p_hit) else $error("match passed");
    property p_flags; take && hit |-> ##3 {O_EXEC_CFG.identify_data_flag,
        O_EXEC_CFG.ultra_dma_enable} == $past(I_BLOCK[23:22], 3); endproperty
    a_flags: assert property (p_flags) else $error("flags");
    property p_dev; take && hit |-> ##3 O_EXEC_CFG.drive_select_bit ==
        $past(I_BLOCK[21] ? I_BLOCK[92] : I_CFG_DRIVE_BYTE[5], 3); endproperty
    a_dev: assert property (p_dev) else $error("drive select");
    property p_halt; take && hit |-> ##3 {O_EXEC_CFG.halt_on_device_err,
        O_EXEC_CFG.halt_on_phase_err} == ~$past(I_BLOCK[20:19], 3); endproperty
    a_halt: assert property (p_halt) else $error("halt select");
    property p_img; O_IMAGE_VALID |->
        O_EXEC_CFG.register_readback_only && !O_EXEC_START; endproperty
    a_img: assert property (p_img) else $error("image");
    property p_go; O_EXEC_START |-> !O_EXEC_CFG.register_readback_only;
    endproperty
    a_go: assert property (p_go) else $error("exec start");
    c_miss: cover property (take && !hit);
    c_img: cover property (O_IMAGE_VALID);
    c_go: cover property (O_EXEC_START);
endmodule

bind ata_cmd_block_decoder ata_cmd_block_decoder_chk chk_i (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_TF_DONE(I_TF_DONE),
    .I_CFG_SIGNATURE(I_CFG_SIGNATURE), .I_CFG_DRIVE_BYTE(I_CFG_DRIVE_BYTE),
    .I_BLOCK_VALID(I_BLOCK_VALID), .I_BLOCK(I_BLOCK),
    .O_BLOCK_READY(O_BLOCK_READY), .O_NORMAL_PATH(O_NORMAL_PATH),
    .O_NORMAL_BLOCK(O_NORMAL_BLOCK), .O_EXEC_CFG(O_EXEC_CFG),
    .O_TF_REQ(O_TF_REQ), .O_EXEC_START(O_EXEC_START),
    .O_IMAGE_VALID(O_IMAGE_VALID)
);

// file: verification/drive_model.sv
`timescale 1ns/1ns
module drive_model
    import cmd_block_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire tf_req_s i_tf,
    input wire logic i_busy,
    input wire logic [1:0] i_lag,
    output logic o_done,
    output logic [7:0] o_rdata
);
    // ----------------
    // Taskfile answers
    // ----------------
    logic pend_r;
    logic [1:0] wait_r;
    logic [2:0] idx_r;
    always_ff @(posedge i_clk)
    begin
        wait_r <= i_req ? i_lag : wait_r - 2'h1;
        if (i_req)
            idx_r <= i_tf.idx;
    end
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
        begin
            pend_r <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 8'h00;
        end
        else
        begin
            o_done <= pend_r && wait_r == 2'h0;
            pend_r <= i_req || (pend_r && wait_r != 2'h0);
            o_rdata <= ~o_rdata;
            if (pend_r && wait_r == 2'h0)
                o_rdata <= idx_r != 3'h0 ? {5'h14, idx_r} : {i_busy, 7'h50};
        end
endmodule

// file: verification/tb_ata_cmd_block_decoder.sv
`timescale 1ns/1ns
module tb_ata_cmd_block_decoder
    import cmd_block_pkg::*;
;
    localparam logic [7:0] SIG = 8'h5a;
    logic clk, rst, valid, done, busy, ready, npath, treq, start, imgv;
    logic [7:0] drvb, rdata;
    logic [1:0] lag;
    logic [2:0] ev;
    logic [127:0] blk, nblk;
    logic [63:0] img;
    exec_cfg_s cfg;
    tf_req_s tf;
    tf_req_s acc[$];
    int fails = 0;
    int checks_done = 0;
    ata_cmd_block_decoder uut (
        .I_CLK_SYS(clk), .I_RST(rst), .I_CFG_SIGNATURE(SIG),
        .I_CFG_DRIVE_BYTE(drvb), .I_BLOCK_VALID(valid), .I_BLOCK(blk),
        .I_TF_DONE(done), .I_TF_RDATA(rdata), .O_BLOCK_READY(ready),
        .O_NORMAL_PATH(npath), .O_NORMAL_BLOCK(nblk), .O_EXEC_CFG(cfg),
        .O_TF_REQ(treq), .O_TF(tf), .O_EXEC_START(start),
        .O_IMAGE_VALID(imgv), .O_IMAGE(img)
    );
    drive_model drv (
        .i_clk(clk), .i_rst(rst), .i_req(treq), .i_tf(tf), .i_busy(busy),
        .i_lag(lag), .o_done(done), .o_rdata(rdata)
    );
    // ---------
    // Helpers
    // ---------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (treq === 1'b1)
            acc.push_back(tf);
    task automatic chk(string what, logic [127:0] seen, logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [127:0] trace();
        logic [127:0] t = '0;
        foreach (acc[i])
            t = {t[115:0], acc[i][11:8], acc[i].wr ? acc[i].data : 8'h00};
        return t;
    endfunction
    task automatic send(logic [7:0] s0, s1, act, sel, b11);
        int n;
        acc.delete();
        @(posedge clk);
        blk <= {32'h3f3e3d3c, b11, 56'h3a393837363534, sel, act, s1, s0};
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        for (n = 0; n < 300; n++)
        begin
            #1;
            if (npath || start || imgv)
                break;
            @(posedge clk);
        end
        ev = {npath, start, imgv};
        if (n == 300)
        begin
            chk("timeout", 128'h0, 128'h1);
            finish_test();
        end
    endtask
    // ---------
    // Scenarios
    // ---------
    task automatic t_miss();
        send(8'h5b, SUBCMD_ATA, 8'h05, 8'hff, 8'h00);
        chk("sig miss", 128'(ev), 128'h4);
        chk("miss copy", nblk, blk);
        send(SIG, 8'h25, 8'h05, 8'hff, 8'h00);
        chk("sub miss", 128'(ev), 128'h4);
        chk("miss access", 128'(acc.size()), 128'h0);
        $display("t_miss done");
    endtask
    task automatic t_read();
        logic [7:0] sel;
        logic [63:0] im;
        logic [127:0] tr;
        lag <= 2'h0;
        for (int j = 0; j < 2; j++)
        begin
            sel = j ? 8'h5a : 8'ha5;
            im = '0;
            tr = '0;
            for (int k = 0; k < 8; k++)
                if (sel[k])
                begin
                    im[8*k+:8] = k ? 8'ha0 + 8'(k) : 8'h50;
                    tr = {tr[115:0], 3'(k), 9'h000};
                end
            send(SIG, SUBCMD_ATA, 8'h05, sel, 8'h00);
            chk("rb done", 128'(ev), 128'h1);
            chk("rb image", 128'(img), 128'(im));
            chk("rb order", trace(), tr);
        end
        $display("t_read done");
    endtask
    task automatic t_poll();
        lag <= 2'h2;
        busy <= 1'b1;
        acc.delete();
        fork
            send(SIG, SUBCMD_ATA, 8'h01, 8'h01, 8'h00);
            begin
                for (int i = 0; i < 300 && acc.size() < 3; i++)
                    @(posedge clk);
                busy <= 1'b0;
            end
        join
        chk("poll reads", 128'(acc.size()), 128'h4);
        chk("poll image", 128'(img), 128'h50);
        $display("t_poll done");
    endtask
    task automatic t_exec();
        logic [7:0] act [4] = '{8'hc4, 8'h3e, 8'h0c, 8'h14};
        logic [6:0] ecf [4] = '{7'h7c, 7'h02, 7'h50, 7'h30};
        logic [35:0] etr [4] = '{36'hd10536737, 36'h536737d00, 12'hd10,
            12'hd10};
        lag <= 2'h3;
        for (int j = 0; j < 4; j++)
        begin
            send(SIG, SUBCMD_ATA, act[j], j < 2 ? 8'h0c : 8'h00, 8'hef);
            chk("ex start", 128'(ev), 128'h2);
            chk("ex cfg", 128'(cfg), 128'(ecf[j]));
            chk("ex order", trace(), 128'(etr[j]));
        end
        $display("t_exec done");
    endtask
    initial
    begin
        rst = 1'b1;
        valid = 1'b0;
        busy = 1'b0;
        lag = 2'h0;
        drvb = 8'h20;
        blk = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_miss();
        t_read();
        t_poll();
        t_exec();
        finish_test();
    end
endmodule
